// [rtl/gtc_timer.sv]
// Gated 16-bit timer with APB register slave and interrupt
//
// Behaviour
// - With timer on, gate enable gates counting; clear means count freely.
// - Gate polarity picks the active level of the gate.
// - Toggle mode: flip-flop flips on each gate rising edge, acts as gate.
// - Clearing toggle mode clears the toggle flip-flop.
// - Single-pulse mode takes control of the gate.
// - Go/done reads 1 while armed, 0 when done or not started.
// - Go/done clears whenever single-pulse mode is cleared.
// - Gate value bit shows the gate state regardless of gate enable.
// - Gate control bits except the gate value bit clear on power-on reset.
// - Five-bit clock select field, reset to zero.
// - Five-bit gate select field, reset to zero.
// - Sixteen-bit counter as high and low bytes, cleared on reset.
// - Timer on bit enables the timer; gate enable needs it.
// - Wide access mode reads the live 16-bit word; a high byte write is buffered until the low byte write or a counter read, which reloads the buffer.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer
  import gtc_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gtc_pkg::ADDR_W+1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source selections from other peripherals
  input wire logic [gtc_pkg::NUM_SRC-1:0] clk_sources,
  input wire logic [gtc_pkg::NUM_SRC-1:0] gate_sources,
  // Interrupt
  output logic irq
);
  import gtc_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] count_r;
  logic [BYTE_W-1:0] high_buf_r;
  logic timer_on_bit_r;
  logic wide_access_mode_r;
  logic gate_enable_r;
  logic gate_polarity_r;
  logic gate_toggle_mode_r;
  logic gate_single_pulse_mode_r;
  logic [SEL_W-1:0] gate_select_field_r;
  logic [SEL_W-1:0] clk_select_field_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [NUM_SRC-1:0] clk_sync;
  logic [NUM_SRC-1:0] gate_sync;
  logic clk_prev_r;
  logic gate_val_prev_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] idx;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic hit_count;
  logic hit_ctrl;
  logic hit_gctl;
  logic hit_gsel;
  logic hit_csel;
  logic hit_stat;
  logic hit_mask;
  logic aligned;
  assign idx = paddr[ADDR_W+1:WORD_SHIFT];
  assign aligned = (paddr[WORD_SHIFT-1:0] == 2'b00);
  assign access = psel & penable;
  assign hit_count = (idx == IDX_COUNT);
  assign hit_ctrl = (idx == IDX_CTRL);
  assign hit_gctl = (idx == IDX_GATE_CTL);
  assign hit_gsel = (idx == IDX_GATE_SEL);
  assign hit_csel = (idx == IDX_CLK_SEL);
  assign hit_stat = (idx == IDX_IRQ_STAT);
  assign hit_mask = (idx == IDX_IRQ_MASK);
  assign mapped = aligned & (hit_count | hit_ctrl | hit_gctl | hit_gsel | hit_csel
                  | hit_stat | hit_mask);
  assign wr = access & pwrite & mapped;
  assign rd = access & ~pwrite & mapped;

  function automatic logic lane_wr(input logic hit, input int unsigned lane);
    return wr & hit & pstrb[lane];
  endfunction : lane_wr

  // ---------------------------------------------------------------
  // Source synchronisers and gate path
  // ---------------------------------------------------------------
  gtc_sync #(.W(NUM_SRC)) u_clk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(clk_sources),
    .dout(clk_sync)
  );
  gtc_sync #(.W(NUM_SRC)) u_gate_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(gate_sources),
    .dout(gate_sync)
  );

  logic clk_sel;
  logic gate_sel;
  logic clk_edge;
  logic gate_eff;
  logic go_done;
  logic sp_done;
  logic go_set;
  logic gate_open;
  logic count_en;
  logic overflow;
  assign clk_sel = clk_sync[clk_select_field_r];
  assign gate_sel = gate_sync[gate_select_field_r];
  assign clk_edge = clk_sel & ~clk_prev_r;
  // Arming only sticks while single-pulse mode is on
  assign go_set = lane_wr(hit_gctl, 0) & pwdata[GC_GO] & pwdata[GC_SPM];

  gtc_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .gate_in(gate_sel),
    .gate_polarity(gate_polarity_r),
    .gate_toggle_mode(gate_toggle_mode_r),
    .gate_single_pulse_mode(gate_single_pulse_mode_r),
    .go_set(go_set),
    .gate_eff(gate_eff),
    .go_done(go_done),
    .sp_done_pulse(sp_done)
  );

  assign gate_open = ~gate_enable_r | gate_eff;
  assign count_en = timer_on_bit_r & gate_open & clk_edge;
  assign overflow = count_en & (&count_r);

  // ---------------------------------------------------------------
  // Counter with byte and wide access
  // ---------------------------------------------------------------
  logic wr_lo;
  logic wr_hi;
  logic [CNT_W-1:0] count_nxt;
  assign wr_lo = lane_wr(hit_count, 0);
  // Wide mode: high lane goes to a buffer, committed with the low byte
  assign wr_hi = lane_wr(hit_count, 1) & ~wide_access_mode_r;
  always_comb begin
    count_nxt = count_r;
    if (count_en) begin
      count_nxt = count_r + CNT_W'(1);
    end
    if (wr_lo && wide_access_mode_r) begin
      count_nxt = {high_buf_r, pwdata[BYTE_W-1:0]};
    end else begin
      if (wr_lo) begin
        count_nxt[BYTE_W-1:0] = pwdata[BYTE_W-1:0];
      end
      if (wr_hi) begin
        count_nxt[CNT_W-1:BYTE_W] = pwdata[CNT_W-1:BYTE_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= CNT_RST;
      high_buf_r <= '0;
      clk_prev_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      clk_prev_r <= clk_sel;
      if (lane_wr(hit_count, 1) && wide_access_mode_r) begin
        high_buf_r <= pwdata[CNT_W-1:BYTE_W];
      end else if (rd && hit_count && wide_access_mode_r) begin
        high_buf_r <= count_r[CNT_W-1:BYTE_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_on_bit_r <= 1'b0;
      wide_access_mode_r <= 1'b0;
      gate_enable_r <= 1'b0;
      gate_polarity_r <= 1'b0;
      gate_toggle_mode_r <= 1'b0;
      gate_single_pulse_mode_r <= 1'b0;
      gate_select_field_r <= SEL_RST;
      clk_select_field_r <= SEL_RST;
      irq_mask_r <= '0;
    end else begin
      if (lane_wr(hit_ctrl, 0)) begin
        timer_on_bit_r <= pwdata[TC_ON];
        wide_access_mode_r <= pwdata[TC_WIDE];
      end
      if (lane_wr(hit_gctl, 0)) begin
        gate_enable_r <= pwdata[GC_EN];
        gate_polarity_r <= pwdata[GC_POL];
        gate_toggle_mode_r <= pwdata[GC_TGL];
        gate_single_pulse_mode_r <= pwdata[GC_SPM];
      end
      if (lane_wr(hit_gsel, 0)) begin
        gate_select_field_r <= pwdata[SEL_W-1:0];
      end
      if (lane_wr(hit_csel, 0)) begin
        clk_select_field_r <= pwdata[SEL_W-1:0];
      end
      if (lane_wr(hit_mask, 0)) begin
        irq_mask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic gate_val_rise;
  assign gate_val_rise = gate_eff & ~gate_val_prev_r;
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_OVF] = overflow;
    irq_evt[IRQ_SPDONE] = sp_done;
    irq_evt[IRQ_GATE] = gate_val_rise;
  end
  // Read clears only what it reported; a later or same-cycle event still sets
  assign irq_stat_nxt = ((rd && hit_stat) ? (irq_stat_r & ~prdata[IRQ_W-1:0]) : irq_stat_r)
                        | irq_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
      // Gate is active right after reset; avoids a false gate event
      gate_val_prev_r <= 1'b1;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      gate_val_prev_r <= gate_eff;
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] rdata;
  logic [BYTE_W-1:0] gctl_rd;
  logic [BYTE_W-1:0] high_rd;
  assign gctl_rd = {gate_enable_r, gate_polarity_r, gate_toggle_mode_r,
                    gate_single_pulse_mode_r, go_done, gate_eff, 2'b00};
  // Wide read returns the live word; the high byte is also latched
  assign high_rd = count_r[CNT_W-1:BYTE_W];
  always_comb begin
    rdata = '0;
    if (hit_count) begin
      rdata[CNT_W-1:0] = {high_rd, count_r[BYTE_W-1:0]};
    end
    if (hit_ctrl) begin
      rdata[TC_WIDE] = wide_access_mode_r;
      rdata[TC_ON] = timer_on_bit_r;
    end
    if (hit_gctl) begin
      rdata[BYTE_W-1:0] = gctl_rd;
    end
    if (hit_gsel) begin
      rdata[SEL_W-1:0] = gate_select_field_r;
    end
    if (hit_csel) begin
      rdata[SEL_W-1:0] = clk_select_field_r;
    end
    if (hit_stat) begin
      rdata[IRQ_W-1:0] = irq_stat_r;
    end
    if (hit_mask) begin
      rdata[IRQ_W-1:0] = irq_mask_r;
    end
  end

  // Zero-wait answer: pready registered high for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PRDATA_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= mapped ? rdata : PRDATA_RST;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_gate_free_run: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_on_bit_r && !gate_enable_r && clk_edge && !wr_lo && !wr_hi)
      |=> count_r == $past(count_r) + CNT_W'(1))
    else $error("free-running count missed");
  a_gate_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    (!gate_toggle_mode_r && !gate_single_pulse_mode_r) |->
      gate_eff == (gate_polarity_r ? gate_sel : !gate_sel))
    else $error("gate polarity wrong");
  a_toggle_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (!gate_toggle_mode_r && !gate_single_pulse_mode_r) ##1 !gate_toggle_mode_r
      |-> !u_gate.tgl_r)
    else $error("toggle flip-flop not cleared");
  a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
    (gate_toggle_mode_r && u_gate.rise) |=> gate_toggle_mode_r && $changed(u_gate.tgl_r)
      or !gate_toggle_mode_r)
    else $error("toggle flip-flop did not flip");
  a_sp_gate_closed: assert property (@(posedge pclk) disable iff (!presetn)
    (gate_single_pulse_mode_r && !u_gate.pulse_r) |-> !gate_eff)
    else $error("single pulse gate leaked");
  a_go_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !gate_single_pulse_mode_r |=> !go_done || gate_single_pulse_mode_r)
    else $error("go/done not cleared");
  a_go_done_arm: assert property (@(posedge pclk) disable iff (!presetn)
    (go_set && gate_single_pulse_mode_r && !go_done) |=> go_done)
    else $error("go/done not armed");
  a_timer_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer_on_bit_r && !wr_lo && !wr_hi) |=> $stable(count_r))
    else $error("counter moved while off");
  a_wide_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && wide_access_mode_r) |=> count_r == {$past(high_buf_r), $past(pwdata[7:0])})
    else $error("wide write wrong");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("pready late");
  c_wide_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_lo && wide_access_mode_r);
  c_sp_done: cover property (@(posedge pclk) disable iff (!presetn) sp_done);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) overflow);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule : gtc_timer
`default_nettype wire

// [rtl/gtc_pkg.sv]
// Package: register map, field layout and reset values of the gated timer
package gtc_pkg;
  localparam int unsigned ADDR_W = 12;
  // Byte-granular printed offsets are kept as word indices
  localparam logic [ADDR_W-1:0] IDX_COUNT = 12'h20C;
  localparam logic [ADDR_W-1:0] IDX_CTRL = 12'h20E;
  localparam logic [ADDR_W-1:0] IDX_GATE_CTL = 12'h20F;
  localparam logic [ADDR_W-1:0] IDX_GATE_SEL = 12'h210;
  localparam logic [ADDR_W-1:0] IDX_CLK_SEL = 12'h211;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 12'h212;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h213;
  localparam int unsigned WORD_SHIFT = 2;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_SRC = 32;
  // Gate control bit positions
  localparam int unsigned GC_EN = 7;
  localparam int unsigned GC_POL = 6;
  localparam int unsigned GC_TGL = 5;
  localparam int unsigned GC_SPM = 4;
  localparam int unsigned GC_GO = 3;
  localparam int unsigned GC_VAL = 2;
  // Timer control bit positions
  localparam int unsigned TC_ON = 0;
  localparam int unsigned TC_WIDE = 1;
  // Interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_SPDONE = 1;
  localparam int unsigned IRQ_GATE = 2;
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
endpackage : gtc_pkg

// [rtl/gtc_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gtc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] agree;
  // Stage one feeds stage two only
  assign agree = ~(s2_r ^ s3_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (agree & s3_r) | (~agree & dout);
    end
  end
endmodule : gtc_sync
`default_nettype wire

// [rtl/gtc_gate.sv]
// Gate path: polarity, toggle flip-flop and single-pulse acquisition
`timescale 1ns/1ps
`default_nettype none
module gtc_gate (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic gate_in,
  input wire logic gate_polarity,
  input wire logic gate_toggle_mode,
  input wire logic gate_single_pulse_mode,
  input wire logic go_set,
  // Status
  output logic gate_eff,
  output logic go_done,
  output logic sp_done_pulse
);
  logic gate_pol;
  logic prev_r;
  logic rise;
  logic tgl_r;
  logic tgl_src;
  logic armed_r;
  logic pulse_r;
  logic src_prev_r;
  logic src_rise;
  assign gate_pol = gate_polarity ? gate_in : ~gate_in;
  assign rise = gate_pol & ~prev_r;
  assign tgl_src = gate_toggle_mode ? tgl_r : gate_pol;
  // Single pulse opens at the first active edge, closes at the next falling one
  assign gate_eff = gate_single_pulse_mode ? pulse_r & tgl_src : tgl_src;
  // Arming waits for an edge, so a gate already active does not fire it
  assign src_rise = tgl_src & ~src_prev_r;
  assign go_done = armed_r;
  assign sp_done_pulse = pulse_r & ~tgl_src & gate_single_pulse_mode;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset gate reads active (low level, low polarity): no false edge
      prev_r <= 1'b1;
      src_prev_r <= 1'b1;
      tgl_r <= 1'b0;
      armed_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      prev_r <= gate_pol;
      src_prev_r <= tgl_src;
      if (!gate_toggle_mode) begin
        tgl_r <= 1'b0;
      end else if (rise) begin
        tgl_r <= ~tgl_r;
      end
      if (!gate_single_pulse_mode) begin
        armed_r <= 1'b0;
        pulse_r <= 1'b0;
      end else if (armed_r && src_rise) begin
        armed_r <= 1'b0;
        pulse_r <= 1'b1;
      end else if (go_set) begin
        armed_r <= 1'b1;
        pulse_r <= 1'b0;
      end else if (pulse_r && !tgl_src) begin
        pulse_r <= 1'b0;
      end
    end
  end
endmodule : gtc_gate
`default_nettype wire

// [sim/gtc_src_model.sv]
// Model of the on-chip clock and gate sources feeding the timer
`timescale 1ns/1ps
`default_nettype none
module gtc_src_model #(
  parameter int unsigned CLK_IDX = 5,
  parameter int unsigned GATE_IDX = 9
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic clk_run,
  input wire logic gate_lvl,
  // Source buses
  output logic [31:0] clk_sources,
  output logic [31:0] gate_sources,
  output logic [15:0] rise_cnt
);
  logic [2:0] phase_r;
  logic noise_r;
  logic gate_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 3'h0;
      noise_r <= 1'b0;
      gate_r <= 1'b0;
      rise_cnt <= 16'h0000;
    end else begin
      noise_r <= ~noise_r;
      gate_r <= gate_lvl;
      phase_r <= clk_run ? phase_r + 3'h1 : 3'h0;
      if (clk_run && phase_r == 3'h3) begin
        rise_cnt <= rise_cnt + 16'h0001;
      end
    end
  end

  // Unselected lines toggle every cycle, so a wrong select shows at once;
  // the source clock stands low while stopped
  always_comb begin
    clk_sources = {32{noise_r}};
    gate_sources = {32{~noise_r}};
    clk_sources[CLK_IDX] = phase_r[2];
    gate_sources[GATE_IDX] = gate_r;
  end
endmodule : gtc_src_model
`default_nettype wire

// [sim/tb_gated_timer_counter_regs.sv]
// Self-checking bench for the gated timer register block
`timescale 1ns/1ps
`default_nettype none
module tb_gated_timer_counter_regs;
  import gtc_pkg::*;
  localparam logic [13:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [13:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [13:0] A_GC = {IDX_GATE_CTL, 2'b00};
  localparam logic [13:0] A_GS = {IDX_GATE_SEL, 2'b00};
  localparam logic [13:0] A_CS = {IDX_CLK_SEL, 2'b00};
  localparam logic [13:0] A_IST = {IDX_IRQ_STAT, 2'b00};
  localparam logic [13:0] A_IMK = {IDX_IRQ_MASK, 2'b00};
  localparam int CLK_I = 5;
  localparam int GATE_I = 9;
  typedef struct packed {
    logic [13:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic [31:0] exp;
    logic err;
  } gtc_row_s;
  localparam gtc_row_s ROWS [5] = '{
    '{A_GS, 32'h0000_003F, 4'h1, 32'h0000_001F, 1'b0},
    '{A_CS, 32'h0000_00FF, 4'h1, 32'h0000_001F, 1'b0},
    '{A_CNT, 32'h0000_1234, 4'h3, 32'h0000_1234, 1'b0},
    '{14'h0000, 32'h0000_00FF, 4'h1, 32'h0000_0000, 1'b1},
    '{A_GS | 14'h0001, 32'h0000_0000, 4'h1, 32'h0000_0000, 1'b1}};

  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] clk_sources;
  logic [31:0] gate_sources;
  logic clk_run = 1'b0;
  logic gate_lvl = 1'b0;
  logic [15:0] rise_cnt;
  logic [15:0] base;
  logic [31:0] rdat;
  logic [31:0] cval;
  logic rerr;
  int error_cnt = 0;
  int samples_checked = 0;

  gtc_timer gtc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clk_sources(clk_sources),
    .gate_sources(gate_sources), .irq(irq));
  gtc_src_model #(.CLK_IDX(CLK_I), .GATE_IDX(GATE_I)) gtc_src_model_inst (.pclk(pclk),
    .presetn(presetn), .clk_run(clk_run), .gate_lvl(gate_lvl), .clk_sources(clk_sources),
    .gate_sources(gate_sources), .rise_cnt(rise_cnt));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit

  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    cmp_bit(pready, 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0, 4'h0);
    cmp_val(rdat & m, exp);
  endtask : rd_chk

  task automatic run_clk(input int n);
    @(posedge pclk);
    clk_run <= 1'b1;
    repeat (n) @(posedge pclk);
    clk_run <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask : run_clk

  task automatic gate_to(input logic v);
    @(posedge pclk);
    gate_lvl <= v;
    repeat (12) @(posedge pclk);
  endtask : gate_to

  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CNT, 32'h0, 32'hFFFF_FFFF);
    rd_chk(A_GC, 32'h0, 32'hFFFF_FFFB);
    rd_chk(A_GS, 32'h0, 32'hFFFF_FFFF);
    rd_chk(A_CS, 32'h0, 32'hFFFF_FFFF);
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].addr, ROWS[i].wdata, ROWS[i].strb);
      cmp_bit(rerr, ROWS[i].err);
      rd_chk(ROWS[i].addr, ROWS[i].exp, 32'hFFFF_FFFF);
      cmp_bit(rerr, ROWS[i].err);
    end
    // Free counting, then timer off
    apb(1'b1, A_CS, 32'(CLK_I), 4'h1);
    apb(1'b1, A_GS, 32'(GATE_I), 4'h1);
    apb(1'b1, A_CNT, 32'h0, 4'h3);
    apb(1'b1, A_CTL, 32'h1, 4'h1);
    base = rise_cnt;
    run_clk(80);
    rd_chk(A_CNT, {16'h0, rise_cnt - base}, 32'hFFFF);
    cval = rdat;
    apb(1'b1, A_CTL, 32'h0, 4'h1);
    run_clk(40);
    rd_chk(A_CNT, cval, 32'hFFFF);
    // Gate enabled, both polarities
    apb(1'b1, A_GC, 32'hC0, 4'h1);
    apb(1'b1, A_CTL, 32'h1, 4'h1);
    run_clk(40);
    rd_chk(A_CNT, cval, 32'hFFFF);
    gate_to(1'b1);
    rd_chk(A_GC, 32'hC4, 32'hFC);
    base = rise_cnt;
    run_clk(40);
    rd_chk(A_CNT, cval + {16'h0, rise_cnt - base}, 32'hFFFF);
    cval = rdat;
    apb(1'b1, A_GC, 32'h80, 4'h1);
    run_clk(40);
    rd_chk(A_CNT, cval, 32'hFFFF);
    apb(1'b1, A_GC, 32'h40, 4'h1);
    rd_chk(A_GC, 32'h44, 32'hFC);
    gate_to(1'b0);
    rd_chk(A_GC, 32'h40, 32'hFC);
    // Toggle mode
    apb(1'b1, A_GC, 32'h60, 4'h1);
    gate_to(1'b1);
    gate_to(1'b0);
    rd_chk(A_GC, 32'h04, 32'h04);
    gate_to(1'b1);
    gate_to(1'b0);
    rd_chk(A_GC, 32'h00, 32'h04);
    gate_to(1'b1);
    gate_to(1'b0);
    apb(1'b1, A_GC, 32'h40, 4'h1);
    apb(1'b1, A_GC, 32'h60, 4'h1);
    rd_chk(A_GC, 32'h00, 32'h04);
    // Single-pulse acquisition
    apb(1'b1, A_GC, 32'h50, 4'h1);
    rd_chk(A_GC, 32'h00, 32'h08);
    apb(1'b1, A_GC, 32'h58, 4'h1);
    rd_chk(A_GC, 32'h08, 32'h08);
    apb(1'b1, A_GC, 32'h40, 4'h1);
    rd_chk(A_GC, 32'h00, 32'h08);
    apb(1'b0, A_IST, 32'h0, 4'h0);
    apb(1'b1, A_GC, 32'h50, 4'h1);
    apb(1'b1, A_GC, 32'h58, 4'h1);
    gate_to(1'b1);
    gate_to(1'b0);
    rd_chk(A_GC, 32'h00, 32'h08);
    // Pulse opened the gate once and then completed
    rd_chk(A_IST, 32'h6, 32'h7);
    apb(1'b1, A_GC, 32'hD0, 4'h1);
    rd_chk(A_CNT, 32'h0, 32'h0);
    cval = rdat;
    gate_to(1'b1);
    run_clk(40);
    rd_chk(A_CNT, cval, 32'hFFFF);
    gate_to(1'b0);
    // Wide access: high byte waits for the low byte write unless a read reloads it
    apb(1'b1, A_GC, 32'h00, 4'h1);
    apb(1'b1, A_CTL, 32'h2, 4'h1);
    apb(1'b1, A_CNT, 32'h0000_AB00, 4'h2);
    apb(1'b1, A_CNT, 32'h0000_00CD, 4'h1);
    rd_chk(A_CNT, 32'hABCD, 32'hFFFF);
    apb(1'b1, A_CNT, 32'h0000_5600, 4'h2);
    rd_chk(A_CNT, 32'hABCD, 32'hFFFF);
    apb(1'b1, A_CNT, 32'h0000_0011, 4'h1);
    rd_chk(A_CNT, 32'hAB11, 32'hFFFF);
    // Overflow interrupt: masked, unmasked, cleared by read
    apb(1'b1, A_CTL, 32'h0, 4'h1);
    apb(1'b1, A_CNT, 32'hFFFF, 4'h3);
    apb(1'b1, A_IMK, 32'h0, 4'h1);
    apb(1'b0, A_IST, 32'h0, 4'h0);
    apb(1'b1, A_CTL, 32'h1, 4'h1);
    run_clk(10);
    apb(1'b1, A_CTL, 32'h0, 4'h1);
    rd_chk(A_CNT, 32'h0, 32'hFFFF);
    cmp_bit(irq, 1'b0);
    apb(1'b1, A_IMK, 32'h1, 4'h1);
    repeat (2) @(posedge pclk);
    cmp_bit(irq, 1'b1);
    rd_chk(A_IST, 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    cmp_bit(irq, 1'b0);
    rd_chk(A_IST, 32'h0, 32'h1);
    // Mid-run reset clears counter and both selects
    apb(1'b1, A_CNT, 32'h0000_5A5A, 4'h3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cmp_bit(irq, 1'b0);
    rd_chk(A_CNT, 32'h0, 32'hFFFF);
    rd_chk(A_GC, 32'h0, 32'hFB);
    rd_chk(A_GS, 32'h0, 32'hFFFF_FFFF);
    rd_chk(A_CS, 32'h0, 32'hFFFF_FFFF);
    rd_chk(A_IST, 32'h0, 32'h7);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    cmp_bit(1'b0, 1'b1);
    finish_test();
  end
endmodule : tb_gated_timer_counter_regs
`default_nettype wire
